// file: rtl/gpsc_pkg.sv
// Purpose: shared constants of the pin status/control block
// Assumes: 32-bit wishbone data, 8-bit registers in byte lane 0
// Notes: register index times four is the byte address
package gpsc_pkg;
  // register indices; byte address = index * 4
  localparam logic [7:0] GPSC_IDX_STRAP = 8'h1C;
  localparam logic [7:0] GPSC_IDX_DIR_LOW = 8'h1E;
  localparam logic [7:0] GPSC_IDX_DIR_HIGH = 8'h1F;
  localparam logic [7:0] GPSC_IDX_STAT_LOW = 8'h20;
  localparam logic [7:0] GPSC_IDX_STAT_HIGH = 8'h21;

  // field positions
  localparam int GPSC_GPO_CTRL_BIT = 7;
  localparam int GPSC_HIGH_PINS = 4;
  localparam int GPSC_PIN_COUNT = 12;
  localparam int GPSC_STRAP_RAMDAC_BIT = 0;
  localparam int GPSC_STRAP_MEM_LSB = 1;
  localparam int GPSC_STRAP_SLEEP_LSB = 3;

  // reset values
  localparam logic [7:0] GPSC_DIR_RST = 8'h00;
  localparam logic [7:0] GPSC_STAT_RST = 8'h00;
  localparam logic [3:0] GPSC_DIR_HIGH_RST = 4'h0;
  localparam logic [3:0] GPSC_STAT_HIGH_RST = 4'h0;
  localparam logic GPSC_GPO_CTRL_RST = 1'b0;

  // memory-size strap value that frees pins 1 to 3
  localparam logic [1:0] GPSC_MEM_STRAP_GPIO = 2'h0;

  // reply timing: ack one cycle after the request is seen
  localparam int GPSC_ACK_LATENCY = 1;

  typedef enum logic [1:0] {
    GPSC_SLEEP_INPUT,
    GPSC_SLEEP_OUT_HIGH,
    GPSC_SLEEP_OUT_LOW
  } gpsc_sleep_mode_t;
endpackage

// file: rtl/gpsc_strap.sv
// Purpose: catch strap levels at the release of reset
// Assumes: straps already synchronised
// Notes: value follows straps while reset is high, then holds
`timescale 1ns/1ps
module gpsc_strap #(
  parameter int WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] strap_i,
  output logic [WIDTH-1:0] latched_o
);
  // synchronous capture; last value seen in reset is kept
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latched_o <= strap_i;
    end
  end
endmodule

// file: rtl/gpsc_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to CLK_I
// Notes: outside reset, output changes only when stages two and three agree
`timescale 1ns/1ps
module gpsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_nxt;

  // stage one is read only by stage two
  always_ff @(posedge clk_i) begin
    s1_r <= async_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // accept a bit only once two late stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign level_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : level_o[g];
    end
  endgenerate

  // reset loads stage three, so no false edge follows release
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_o <= s3_r;
    end else begin
      level_o <= level_nxt;
    end
  end
endmodule

// file: rtl/gpsc_top.sv
// Purpose: twelve-pin general i/o port with one general output
// Assumes: classic wishbone slave, 32-bit data, lane 0 used
// Notes: alternate functions come from other chip logic
`timescale 1ns/1ps

module gpsc_top
  import gpsc_pkg::*;
#(
  parameter logic [1:0] MEM_STRAP_GPIO = gpsc_pkg::GPSC_MEM_STRAP_GPIO
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  // multi-function pins
  input wire logic [gpsc_pkg::GPSC_PIN_COUNT-1:0] PIN_IN_I,
  output logic [gpsc_pkg::GPSC_PIN_COUNT-1:0] PIN_OUT_O,
  output logic [gpsc_pkg::GPSC_PIN_COUNT-1:0] PIN_OE_N_O,
  // alternate function sources
  input wire logic MEM_ADDR_LINE_9_I,
  input wire logic MEM_ADDR_LINE_10_I,
  input wire logic MEM_ADDR_LINE_11_I,
  input wire logic DAC_READ_STROBE_I,
  input wire logic DAC_BLANK_I,
  input wire logic DAC_PALETTE_BIT_I,
  input wire logic DAC_WRITE_STROBE_I,
  input wire logic DAC_SELECT_0_I,
  input wire logic DAC_SELECT_1_I,
  input wire logic CRT_HSYNC_I,
  input wire logic CRT_VSYNC_I,
  // straps
  input wire logic RAMDAC_STRAP_I,
  input wire logic [1:0] MEMORY_SIZE_STRAP_I,
  input wire logic [1:0] SLEEP_PIN_STRAP_I,
  // sleep pin
  input wire logic SLEEP_PIN_IN_I,
  output logic SLEEP_PIN_OUT_O,
  output logic SLEEP_PIN_OE_N_O,
  output logic SUSPEND_REQ_O
);
  import gpsc_pkg::*;

  localparam int NP = GPSC_PIN_COUNT;
  localparam int NH = GPSC_HIGH_PINS;

  // index match on a word address
  function automatic logic idx_hit(input logic [9:0] adr,
                                   input logic [7:0] idx);
    idx_hit = (adr[9:2] == idx);
  endfunction

  // register state
  logic [7:0] dir_low_r;
  logic [NH-1:0] dir_high_r;
  logic [7:0] stat_low_r;
  logic [NH-1:0] stat_high_r;
  logic gpo_ctrl_r;

  // synchronised inputs
  logic [NP-1:0] pin_lvl;
  logic sleep_lvl;
  logic [4:0] strap_lvl;
  logic [4:0] strap_lat;

  // bus
  logic req;
  logic hit_strap;
  logic hit_dir_lo;
  logic hit_dir_hi;
  logic hit_stat_lo;
  logic hit_stat_hi;
  logic mapped;
  logic wr_fire;
  logic wr_lane0;
  logic wr_dir_lo;
  logic wr_dir_hi;
  logic wr_stat_lo;
  logic wr_stat_hi;
  logic ack_r;
  logic ack_nxt;
  logic err_r;
  logic err_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [7:0] rd_byte;
  logic [7:0] rd_strap;
  logic [7:0] rd_dir_hi;
  logic [7:0] rd_stat_lo;
  logic [7:0] rd_stat_hi;

  // pin mux
  logic ramdac_gpio;
  logic mem_gpio;
  logic [NP-1:0] gpio_en;
  logic [NP-1:0] dir_all;
  logic [NP-1:0] stat_all;
  logic [NP-1:0] alt_out;
  logic [NP-1:0] rd_level;
  logic [NP-1:0] out_r;
  logic [NP-1:0] out_nxt;
  logic [NP-1:0] oe_n_r;
  logic [NP-1:0] oe_n_nxt;

  // sleep pin
  gpsc_sleep_mode_t sleep_mode;
  logic gpo_rst_level;
  logic sleep_in_mode;
  logic sleep_out_r;
  logic sleep_out_nxt;
  logic sleep_oe_n_r;
  logic sleep_oe_n_nxt;
  logic susp_r;
  logic susp_nxt;

  // pins and straps pass three stages
  gpsc_sync #(
    .WIDTH(NP + 1)
  ) u_pin_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .async_i({SLEEP_PIN_IN_I, PIN_IN_I}),
    .level_o({sleep_lvl, pin_lvl})
  );

  gpsc_sync #(
    .WIDTH(5)
  ) u_strap_sync (
    .clk_i(CLK_I),
    .reset_i(1'b0),
    .async_i({SLEEP_PIN_STRAP_I, MEMORY_SIZE_STRAP_I, RAMDAC_STRAP_I}),
    .level_o(strap_lvl)
  );

  // straps held from the release of reset on
  gpsc_strap #(
    .WIDTH(5)
  ) u_strap (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .strap_i(strap_lvl),
    .latched_o(strap_lat)
  );

  // pin ownership decided by the straps
  assign ramdac_gpio = strap_lat[GPSC_STRAP_RAMDAC_BIT];
  assign mem_gpio =
    (strap_lat[GPSC_STRAP_MEM_LSB +: 2] == MEM_STRAP_GPIO);
  assign gpio_en[0] = 1'b1;
  assign gpio_en[3:1] = {3{mem_gpio}};
  assign gpio_en[7:4] = {4{ramdac_gpio}};
  assign gpio_en[11:8] = {4{ramdac_gpio}};

  // alternate function drive per pin
  assign alt_out[0] = 1'b0;
  assign alt_out[1] = MEM_ADDR_LINE_10_I;
  assign alt_out[2] = MEM_ADDR_LINE_11_I;
  assign alt_out[3] = MEM_ADDR_LINE_9_I;
  assign alt_out[4] = DAC_READ_STROBE_I;
  assign alt_out[5] = DAC_BLANK_I;
  assign alt_out[6] = DAC_PALETTE_BIT_I;
  assign alt_out[7] = DAC_WRITE_STROBE_I;
  assign alt_out[8] = DAC_SELECT_0_I;
  assign alt_out[9] = DAC_SELECT_1_I;
  assign alt_out[10] = CRT_HSYNC_I;
  assign alt_out[11] = CRT_VSYNC_I;

  // flat views of direction and status bits
  assign dir_all = {dir_high_r, dir_low_r};
  assign stat_all = {stat_high_r, stat_low_r};

  // per-pin mux; alternate function always drives its pin
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      // status bit drives a free output pin
      assign out_nxt[g] =
        gpio_en[g] ? stat_all[g] : alt_out[g];
      // direction one drives, zero releases
      assign oe_n_nxt[g] =
        gpio_en[g] ? ~dir_all[g] : 1'b0;
      // free input pin reads its live level
      assign rd_level[g] = (gpio_en[g] && !dir_all[g]) ?
        pin_lvl[g] : stat_all[g];
    end
  endgenerate

  // pin outputs straight from flops
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      out_r <= '0;
      oe_n_r <= '1;
    end else begin
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // sleep pin role from its two strap bits
  assign sleep_mode =
    !strap_lat[GPSC_STRAP_SLEEP_LSB] ? GPSC_SLEEP_INPUT :
    strap_lat[GPSC_STRAP_SLEEP_LSB + 1] ? GPSC_SLEEP_OUT_LOW :
    GPSC_SLEEP_OUT_HIGH;

  // one named decode shared by drive, enable and suspend
  assign sleep_in_mode = (sleep_mode == GPSC_SLEEP_INPUT);

  // reset level: 01 gives high, 11 gives low
  assign gpo_rst_level =
    (sleep_mode == GPSC_SLEEP_OUT_HIGH);

  // control bit zero keeps reset level, one inverts
  assign sleep_out_nxt = sleep_in_mode ? 1'b0 :
    (gpo_rst_level ^ gpo_ctrl_r);
  // input mode never drives; control bit ignored there
  assign sleep_oe_n_nxt = sleep_in_mode;
  // active-low suspend request only in input mode
  assign susp_nxt = sleep_in_mode && !sleep_lvl;

  // sleep pin flops; strap is not known until release
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sleep_out_r <= 1'b0;
      sleep_oe_n_r <= 1'b1;
      susp_r <= 1'b0;
    end else begin
      sleep_out_r <= sleep_out_nxt;
      sleep_oe_n_r <= sleep_oe_n_nxt;
      susp_r <= susp_nxt;
    end
  end

  // address decode
  assign req = CYC_I && STB_I;
  assign hit_strap = idx_hit(ADR_I, GPSC_IDX_STRAP);
  assign hit_dir_lo = idx_hit(ADR_I, GPSC_IDX_DIR_LOW);
  assign hit_dir_hi = idx_hit(ADR_I, GPSC_IDX_DIR_HIGH);
  assign hit_stat_lo = idx_hit(ADR_I, GPSC_IDX_STAT_LOW);
  assign hit_stat_hi = idx_hit(ADR_I, GPSC_IDX_STAT_HIGH);
  assign mapped = hit_strap || hit_dir_lo || hit_dir_hi ||
    hit_stat_lo || hit_stat_hi;

  // one reply per request, dropped the cycle after
  assign ack_nxt = req && mapped && !ack_r && !err_r;
  assign err_nxt = req && !mapped && !ack_r && !err_r;

  // write lands at the edge where the master sees ack
  assign wr_fire = req && WE_I && ack_r;
  assign wr_lane0 = wr_fire && SEL_I[0];

  // per-register strobes; the strap copy is read-only, none there
  assign wr_dir_lo = wr_lane0 && hit_dir_lo;
  assign wr_dir_hi = wr_lane0 && hit_dir_hi;
  assign wr_stat_lo = wr_lane0 && hit_stat_lo;
  assign wr_stat_hi = wr_lane0 && hit_stat_hi;

  // padded read words; unused bits read zero
  assign rd_strap = {3'h0, strap_lat};
  assign rd_dir_hi = {4'h0, dir_high_r};
  assign rd_stat_lo = rd_level[7:0];
  assign rd_stat_hi = {gpo_ctrl_r, 3'h0, rd_level[11:8]};

  // read mux; an unmapped index reads zero
  assign rd_byte =
    hit_strap ? rd_strap :
    hit_dir_lo ? dir_low_r :
    hit_dir_hi ? rd_dir_hi :
    hit_stat_lo ? rd_stat_lo :
    hit_stat_hi ? rd_stat_hi :
    8'h00;
  assign dat_nxt = ack_nxt ? {24'h000000, rd_byte} : 32'h00000000;

  // bus reply flops
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      dat_r <= dat_nxt;
    end
  end

  // direction registers; input after reset
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      dir_low_r <= GPSC_DIR_RST;
      dir_high_r <= GPSC_DIR_HIGH_RST;
    end else begin
      if (wr_dir_lo) begin
        dir_low_r <= DAT_I[7:0];
      end
      if (wr_dir_hi) begin
        dir_high_r <= DAT_I[NH-1:0];
      end
    end
  end

  // status/control registers; bits 6..4 of high unused
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      stat_low_r <= GPSC_STAT_RST;
      stat_high_r <= GPSC_STAT_HIGH_RST;
      gpo_ctrl_r <= GPSC_GPO_CTRL_RST;
    end else begin
      if (wr_stat_lo) begin
        stat_low_r <= DAT_I[7:0];
      end
      if (wr_stat_hi) begin
        stat_high_r <= DAT_I[NH-1:0];
        gpo_ctrl_r <= DAT_I[GPSC_GPO_CTRL_BIT];
      end
    end
  end

  // outputs
  assign ACK_O = ack_r;
  assign ERR_O = err_r;
  assign DAT_O = dat_r;
  assign PIN_OUT_O = out_r;
  assign PIN_OE_N_O = oe_n_r;
  assign SLEEP_PIN_OUT_O = sleep_out_r;
  assign SLEEP_PIN_OE_N_O = sleep_oe_n_r;
  assign SUSPEND_REQ_O = susp_r;
endmodule

// file: tb/gpsc_pin_model.sv
// Purpose: far-side circuits seen by the port pins
// Assumes: no pull resistors; outside drive only where device lets go
// Notes: pin level is device level when driven, else outside level
`timescale 1ns/1ps
module gpsc_pin_model (
  input wire logic [11:0] out_i,
  input wire logic [11:0] oe_n_i,
  input wire logic [11:0] ext_i,
  input wire logic sl_out_i,
  input wire logic sl_oe_n_i,
  input wire logic sl_ext_i,
  output logic [11:0] level_o,
  output logic sl_level_o
);
  // wire resolution; outside never fights a driven pin
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
  assign sl_level_o = sl_oe_n_i ? sl_ext_i : sl_out_i;
endmodule

// file: tb/gpsc_top_properties.sv
// Purpose: bus and strap checks on the port pins
// Assumes: straps stable while reset is high
// Notes: strap copy waits three edges so outputs have settled
`timescale 1ns/1ps
module gpsc_top_checker
  import gpsc_pkg::*;
#(
  parameter logic [1:0] MEM_STRAP_GPIO = 2'h0
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic [9:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic ERR_O,
  input wire logic [11:0] PIN_OE_N_O,
  input wire logic RAMDAC_STRAP_I,
  input wire logic [1:0] MEMORY_SIZE_STRAP_I,
  input wire logic [1:0] SLEEP_PIN_STRAP_I,
  input wire logic SLEEP_PIN_OE_N_O,
  input wire logic SUSPEND_REQ_O
);
  logic [4:0] strap_r;
  logic [1:0] run_r;
  wire req = CYC_I & STB_I;
  wire [7:0] idx = ADR_I[9:2];
  wire mapped = idx inside {8'h1C, 8'h1E, 8'h1F, 8'h20, 8'h21};
  wire settled = run_r == 2'h3;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // own strap copy; settle count hides the reset-release edge
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      strap_r <= {SLEEP_PIN_STRAP_I, MEMORY_SIZE_STRAP_I, RAMDAC_STRAP_I};
      run_r <= 2'h0;
    end else if (!settled) begin
      run_r <= run_r + 2'h1;
    end
  end
  chk_ack_mapped: assert property ($rose(req) && mapped |=> ACK_O && !ERR_O)
    else $error("no ack after mapped request");
  chk_err_unmapped: assert property ($rose(req) && !mapped |=> ERR_O && !ACK_O)
    else $error("no err after unmapped request");
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside ack");
  chk_ramdac_alt: assert property (
    settled && !strap_r[0] |-> PIN_OE_N_O[11:4] == 8'h00)
    else $error("ramdac pins not driven");
  chk_mem_alt: assert property (
    settled && strap_r[2:1] != MEM_STRAP_GPIO |-> PIN_OE_N_O[3:1] == 3'h0)
    else $error("address pins not driven");
  chk_sleep_dir: assert property (
    settled |-> SLEEP_PIN_OE_N_O == !strap_r[3])
    else $error("sleep pin direction wrong");
  chk_suspend_off: assert property (strap_r[3] |-> !SUSPEND_REQ_O)
    else $error("suspend while pin is output");
  cover property ($rose(req) && !mapped);
  cover property (settled && !strap_r[0]);
  cover property (SUSPEND_REQ_O);
endmodule
bind gpsc_top gpsc_top_checker #(.MEM_STRAP_GPIO(MEM_STRAP_GPIO)) i_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O),
  .PIN_OE_N_O(PIN_OE_N_O), .RAMDAC_STRAP_I(RAMDAC_STRAP_I),
  .MEMORY_SIZE_STRAP_I(MEMORY_SIZE_STRAP_I),
  .SLEEP_PIN_STRAP_I(SLEEP_PIN_STRAP_I),
  .SLEEP_PIN_OE_N_O(SLEEP_PIN_OE_N_O), .SUSPEND_REQ_O(SUSPEND_REQ_O));

// file: tb/test_gpsc_top.sv
// Purpose: self-checking bench of the pin status/control port
// Assumes: classic wishbone master, straps held through reset
// Notes: three resets walk the strap modes
`timescale 1ns/1ps
module test_gpsc_top;
  import gpsc_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ram = 1, sl_in = 1;
  logic [9:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, dat_o, rdat, lf = 32'hFC75;
  logic [11:0] pin_in, pin_out, pin_oe_n, ext = 0;
  logic [10:0] alt = 0;
  logic [1:0] mem = 0, slp = 0;
  logic ack, err, er, sl_out, sl_oe_n, susp, sl_lvl, spur;
  int n_fail = 0, comparisons = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  gpsc_pin_model i_pins (.out_i(pin_out), .oe_n_i(pin_oe_n), .ext_i(ext),
    .sl_out_i(sl_out), .sl_oe_n_i(sl_oe_n), .sl_ext_i(sl_in),
    .level_o(pin_in), .sl_level_o(sl_lvl));
  gpsc_top i_dut (.CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o),
    .ACK_O(ack), .ERR_O(err), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
    .PIN_OE_N_O(pin_oe_n), .MEM_ADDR_LINE_10_I(alt[0]),
    .MEM_ADDR_LINE_11_I(alt[1]), .MEM_ADDR_LINE_9_I(alt[2]),
    .DAC_READ_STROBE_I(alt[3]), .DAC_BLANK_I(alt[4]),
    .DAC_PALETTE_BIT_I(alt[5]), .DAC_WRITE_STROBE_I(alt[6]),
    .DAC_SELECT_0_I(alt[7]), .DAC_SELECT_1_I(alt[8]),
    .CRT_HSYNC_I(alt[9]), .CRT_VSYNC_I(alt[10]), .RAMDAC_STRAP_I(ram),
    .MEMORY_SIZE_STRAP_I(mem), .SLEEP_PIN_STRAP_I(slp),
    .SLEEP_PIN_IN_I(sl_lvl), .SLEEP_PIN_OUT_O(sl_out),
    .SLEEP_PIN_OE_N_O(sl_oe_n), .SUSPEND_REQ_O(susp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; request held until ack or err; watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d,
      input logic [3:0] s = 4'h1);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {ix, 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rdat = dat_o;
    er = err;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic boot(input logic r, input logic [1:0] m, s);
    @(posedge clk);
    rst <= 1;
    ram <= r;
    mem <= m;
    slp <= s;
    repeat (10) @(posedge clk);
    rst <= 0;
    spur = 0;
    // any suspend pulse right after release is a false edge
    repeat (4) begin
      @(negedge clk);
      spur |= susp;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    logic [7:0] dl, dh, sl, sh;
    boot(1, 2'b00, 2'b01);
    wb(1, GPSC_IDX_STRAP, 8'hFF);
    wb(0, GPSC_IDX_STRAP, 0);
    chk("strap", 32'h09, rdat);
    wb(0, GPSC_IDX_DIR_LOW, 0);
    chk("dir_rst", 32'h0, rdat);
    chk("oe_rst", 32'hFFF, pin_oe_n);
    chk("gpo_rst", 1, sl_out);
    chk("gpo_oe", 0, sl_oe_n);
    wb(1, GPSC_IDX_STAT_HIGH, 8'hF0);
    repeat (3) @(negedge clk);
    chk("gpo_inv", 0, sl_out);
    wb(0, GPSC_IDX_STAT_HIGH, 0);
    chk("stat_high", 32'h80, rdat);
    wb(0, 8'h05, 0);
    chk("unmapped", 1, er);
    for (int i = 0; i < 20; i++) begin
      lf = lfsr(lf);
      dl = lf[7:0];
      dh = {4'h0, lf[11:10], lf[9], lf[9]};
      sl = lf[23:16];
      sh = {4'h0, lf[27:24]};
      ext <= lf[31:20];
      wb(1, GPSC_IDX_DIR_LOW, dl);
      wb(1, GPSC_IDX_DIR_HIGH, dh);
      wb(1, GPSC_IDX_STAT_LOW, sl);
      wb(1, GPSC_IDX_STAT_HIGH, sh);
      repeat (6) @(negedge clk);
      chk("oe_n", 12'(~{dh[3:0], dl}), pin_oe_n);
      chk("out", {dh, dl} & {sh, sl}, {dh, dl} & pin_out);
      wb(1, GPSC_IDX_STAT_LOW, ~sl, 4'h0);
      wb(0, GPSC_IDX_STAT_LOW, 0);
      chk("in_low", (dl & sl) | (~dl & ext[7:0]), rdat);
      wb(0, GPSC_IDX_STAT_HIGH, 0);
      chk("in_high", (dh & sh) | (~dh & ext[11:8]), rdat);
    end
    $display("test free_pins done");
    boot(0, 2'b01, 2'b11);
    chk("gpo_rst_low", 0, sl_out);
    chk("gpo_oe_low", 0, sl_oe_n);
    wb(1, GPSC_IDX_DIR_LOW, 8'h01);
    wb(1, GPSC_IDX_STAT_LOW, 8'h01);
    alt <= lf[10:0];
    repeat (6) @(negedge clk);
    chk("alt_out", {alt, 1'b1}, pin_out);
    chk("alt_oe", 0, pin_oe_n);
    wb(1, GPSC_IDX_STAT_HIGH, 8'h80);
    repeat (3) @(negedge clk);
    chk("gpo_inv_low", 1, sl_out);
    $display("test alt_pins done");
    boot(1, 2'b00, 2'b10);
    chk("sleep_oe", 1, sl_oe_n);
    chk("suspend_idle", 0, spur);
    wb(1, GPSC_IDX_STAT_HIGH, 8'h80);
    sl_in <= 0;
    repeat (6) @(negedge clk);
    chk("suspend_on", 1, susp);
    chk("sleep_oe_ctl", 1, sl_oe_n);
    sl_in <= 1;
    repeat (6) @(negedge clk);
    chk("suspend_off", 0, susp);
    $display("test sleep_input done");
    final_report();
  end
endmodule
